// [shared/cbc_pkg.sv]
// constants and types for the bus cycle control block
// Function
// - ratio strap caught at reset, held until a later long cold reset.
// - abort-retry aborts open cycles and floats hold pins next clock.
// - stay in hold while abort-retry low, then restart aborted cycle whole.
// - four breakpoint outputs, one per debug address register match.
// - shared pins come out of reset in monitor function.
// - burst-ready marks data valid or taken; sampled only in T2, T12, T2P.
// - copy of burst-ready acts exactly like burst-ready.
// - bus request output always driven, high while request is pending.
// - bus-check active captures cycle address and control into check regs.
// - with check enable set, bus-check raises the machine check exception.
// - snoop bus-check under stop-clock raises exception after its release.
// - second snoop to same line under stop-clock may drop pending check.
// - read data captured in the clock burst-ready is returned.
// - all controls sampled and driven on the rising bus clock edge.
package cbc_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned COLD_RESET_US = 1000;
  localparam int unsigned COLD_RESET_CYC = COLD_RESET_US * CLK_MHZ;
  localparam int AW = 29;
  localparam int DW = 64;
  localparam int RA = 4;
  // register offsets
  localparam logic [RA-1:0] REG_CTRL = 4'h0;
  localparam logic [RA-1:0] REG_STAT = 4'h1;
  localparam logic [RA-1:0] REG_MASK = 4'h2;
  localparam logic [RA-1:0] REG_MCA = 4'h3;
  localparam logic [RA-1:0] REG_MCT = 4'h4;
  localparam logic [RA-1:0] REG_DLO = 4'h5;
  localparam logic [RA-1:0] REG_DHI = 4'h6;
  // control register fields
  localparam int CTRL_SEL_LO = 0;
  localparam int CTRL_SEL_HI = 1;
  localparam int CTRL_MCE = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status bit positions
  localparam int EV_MCHK = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_DONE = 2;
  localparam int EV_DROP = 3;
  localparam int NEV = 4;
  localparam logic [AW-1:0] ADDR_ZERO = 29'h0;
  localparam logic [DW-1:0] DATA_ZERO = 64'h0;
  localparam logic [1:0] STRAP_RESET = 2'h0;

  // bus states, gray coded along idle-addr-data-hold path
  typedef enum logic [2:0] {
    CBC_IDLE = 3'h0,
    CBC_T1 = 3'h1,
    CBC_T2 = 3'h3,
    CBC_T12 = 3'h2,
    CBC_T2P = 3'h6,
    CBC_HOLD = 3'h4
  } cbc_state_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic write;
    logic snoop;
  } cbc_cycle_s;
endpackage : cbc_pkg

// [design/cbc_bus_ctrl.sv]
// bus cycle control: ratio strap, abort-retry, burst-ready, bus check
`timescale 1ns/1ps
module cbc_bus_ctrl #(
  parameter int unsigned COLD_RESET_CYC = cbc_pkg::COLD_RESET_CYC
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // straps and bus pins
  input wire logic [1:0] BUS_RATIO_STRAP_I,
  input wire logic ABORT_RETRY_N_I,
  input wire logic BURST_READY_N_I,
  input wire logic BURST_READY_COPY_N_I,
  input wire logic BUS_CHECK_N_I,
  input wire logic STOP_CLOCK_REQUEST_N_I,
  input wire logic [cbc_pkg::DW-1:0] DATA_I,
  output logic BUS_REQUEST_OUT_O,
  output logic CYCLE_START_O,
  output logic [cbc_pkg::AW-1:0] ADDR_O,
  output logic ADDR_OE_O,
  output logic WRITE_O,
  output logic [1:0] BUS_RATIO_O,
  // core side
  input wire logic REQ_VALID_I,
  input wire cbc_pkg::cbc_cycle_s REQ_CYCLE_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  // debug and monitor
  input wire logic [3:0] BREAK_MATCH_I,
  input wire logic [1:0] PERF_MON_I,
  output logic [1:0] BREAKPOINT_OUT_O,
  output logic [1:0] SHARED_MONITOR_BREAK_OUT_O,
  // register port
  input wire logic [cbc_pkg::RA-1:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  output logic MACHINE_CHECK_O,
  output logic IRQ_O
);
  localparam logic [31:0] COLD_LIM = 32'(COLD_RESET_CYC);
  // two-flop pin synchronisers
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [cbc_pkg::DW-1:0] dat1_q;
  logic [cbc_pkg::DW-1:0] dat2_q;
  always_ff @(posedge CORE_CLK_I) begin
    s1_q <= {BUS_RATIO_STRAP_I, ABORT_RETRY_N_I, BURST_READY_N_I,
             BURST_READY_COPY_N_I, BUS_CHECK_N_I, STOP_CLOCK_REQUEST_N_I};
    s2_q <= s1_q;
    dat1_q <= DATA_I;
    dat2_q <= dat1_q;
  end
  wire [1:0] strap = s2_q[6:5];
  wire abort_act = !s2_q[4];
  wire rdy_act = !s2_q[3] || !s2_q[2];
  wire chk_act = !s2_q[1];
  wire stop_act = !s2_q[0];

  // ratio strap latched after a long reset or at first power-up
  logic [31:0] rst_cnt_q;
  logic strap_take_q;
  logic [1:0] ratio_q;
  wire cold = rst_cnt_q >= COLD_LIM;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rst_cnt_q <= cold ? rst_cnt_q : rst_cnt_q + 32'h1;
      strap_take_q <= cold;
    end else begin
      rst_cnt_q <= 32'h0;
      strap_take_q <= 1'b0;
    end
  end
  // first power-up also takes strap
  logic first_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      first_q <= first_q;
    end else begin
      first_q <= 1'b1;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I && (strap_take_q || first_q !== 1'b1)) begin
      ratio_q <= strap;
    end
  end
  assign BUS_RATIO_O = ratio_q;

  // register file
  logic [31:0] ctrl_q;
  logic [cbc_pkg::NEV-1:0] stat_q;
  logic [cbc_pkg::NEV-1:0] mask_q;
  logic [cbc_pkg::AW-1:0] mca_q;
  logic [1:0] mct_q;
  logic [cbc_pkg::DW-1:0] rdat_q;
  logic [31:0] rd_q;
  wire ctrl_wr = REG_WR_I && REG_ADDR_I == cbc_pkg::REG_CTRL;
  wire stat_wr = REG_WR_I && REG_ADDR_I == cbc_pkg::REG_STAT;
  wire mask_wr = REG_WR_I && REG_ADDR_I == cbc_pkg::REG_MASK;
  wire machine_check_enable_bit = ctrl_q[cbc_pkg::CTRL_MCE];

  // bus state machine
  cbc_pkg::cbc_state_e st_q;
  cbc_pkg::cbc_state_e st_d;
  cbc_pkg::cbc_cycle_s cyc_q;
  logic busy_q;
  wire data_phase = st_q == cbc_pkg::CBC_T2 || st_q == cbc_pkg::CBC_T12 ||
                    st_q == cbc_pkg::CBC_T2P;
  wire rdy_take = data_phase && rdy_act;
  wire chk_take = data_phase && chk_act;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      cbc_pkg::CBC_IDLE: if (busy_q) st_d = cbc_pkg::CBC_T1;
      cbc_pkg::CBC_T1: st_d = cbc_pkg::CBC_T2;
      cbc_pkg::CBC_T2: if (rdy_take) st_d = cbc_pkg::CBC_IDLE;
      cbc_pkg::CBC_T12: if (rdy_take) st_d = cbc_pkg::CBC_IDLE;
      cbc_pkg::CBC_T2P: if (rdy_take) st_d = cbc_pkg::CBC_IDLE;
      cbc_pkg::CBC_HOLD: if (!abort_act) st_d = cbc_pkg::CBC_IDLE;
      default: st_d = cbc_pkg::CBC_IDLE;
    endcase
    if (abort_act) st_d = cbc_pkg::CBC_HOLD;
  end
  assign REQ_READY_O = !busy_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      st_q <= cbc_pkg::CBC_IDLE;
      busy_q <= 1'b0;
      cyc_q <= '0;
    end else begin
      st_q <= st_d;
      if (REQ_VALID_I && !busy_q) begin
        busy_q <= 1'b1;
        cyc_q <= REQ_CYCLE_I;
      end else if (rdy_take && !abort_act) begin
        busy_q <= 1'b0;
      end
    end
  end
  // aborted cycle keeps busy_q and cyc_q, so it restarts from T1
  logic done_q;
  logic start_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      done_q <= 1'b0;
      start_q <= 1'b0;
      rdat_q <= cbc_pkg::DATA_ZERO;
    end else begin
      done_q <= rdy_take && !abort_act;
      start_q <= st_d == cbc_pkg::CBC_T1 && !abort_act;
      if (rdy_take && !cyc_q.write) rdat_q <= dat2_q;
    end
  end
  assign DONE_O = done_q;
  assign CYCLE_START_O = start_q;
  assign ADDR_O = cyc_q.addr;
  assign WRITE_O = cyc_q.write;
  assign ADDR_OE_O = st_q != cbc_pkg::CBC_HOLD && st_q != cbc_pkg::CBC_IDLE;
  assign BUS_REQUEST_OUT_O = busy_q;

  // machine check capture and deferral
  logic pend_q;
  logic mchk_q;
  logic [cbc_pkg::AW-1:0] pend_line_q;
  wire snoop_hit = stop_act && pend_q && chk_take && cyc_q.snoop &&
                   cyc_q.addr == pend_line_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      mca_q <= cbc_pkg::ADDR_ZERO;
      mct_q <= 2'h0;
      pend_q <= 1'b0;
      pend_line_q <= cbc_pkg::ADDR_ZERO;
      mchk_q <= 1'b0;
    end else begin
      mchk_q <= 1'b0;
      if (chk_take) begin
        mca_q <= cyc_q.addr;
        mct_q <= {cyc_q.snoop, cyc_q.write};
      end
      if (snoop_hit) begin
        pend_q <= 1'b0;
      end else if (chk_take && machine_check_enable_bit && stop_act && cyc_q.snoop) begin
        pend_q <= 1'b1;
        pend_line_q <= cyc_q.addr;
      end else if (chk_take && machine_check_enable_bit) begin
        mchk_q <= 1'b1;
      end else if (pend_q && !stop_act) begin
        pend_q <= 1'b0;
        mchk_q <= 1'b1;
      end
    end
  end
  assign MACHINE_CHECK_O = mchk_q;

  // sticky status, set wins over clear
  wire [cbc_pkg::NEV-1:0] ev = {snoop_hit, done_q, abort_act &&
                                st_q != cbc_pkg::CBC_HOLD, mchk_q};
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ctrl_q <= cbc_pkg::CTRL_RESET;
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      if (ctrl_wr) ctrl_q <= REG_WDATA_I;
      if (mask_wr) mask_q <= REG_WDATA_I[cbc_pkg::NEV-1:0];
      stat_q <= (stat_q & ~(stat_wr ? REG_WDATA_I[cbc_pkg::NEV-1:0] : '0)) |
                ev;
    end
  end
  assign IRQ_O = |(stat_q & mask_q);

  // read port
  wire [31:0] rd_mux =
    REG_ADDR_I == cbc_pkg::REG_CTRL ? ctrl_q :
    REG_ADDR_I == cbc_pkg::REG_STAT ? {28'h0, stat_q} :
    REG_ADDR_I == cbc_pkg::REG_MASK ? {28'h0, mask_q} :
    REG_ADDR_I == cbc_pkg::REG_MCA ? {3'h0, mca_q} :
    REG_ADDR_I == cbc_pkg::REG_MCT ? {30'h0, mct_q} :
    REG_ADDR_I == cbc_pkg::REG_DLO ? rdat_q[31:0] :
    REG_ADDR_I == cbc_pkg::REG_DHI ? rdat_q[63:32] : 32'h0;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rd_q <= 32'h0;
    end else begin
      rd_q <= REG_RD_I ? rd_mux : 32'h0;
    end
  end
  assign REG_RDATA_O = rd_q;

  // breakpoint and monitor pins
  logic [3:0] bp_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      bp_q <= 4'h0;
    end else begin
      bp_q[3:2] <= BREAK_MATCH_I[3:2];
      bp_q[0] <= ctrl_q[cbc_pkg::CTRL_SEL_LO] ? BREAK_MATCH_I[0] :
                 PERF_MON_I[0];
      bp_q[1] <= ctrl_q[cbc_pkg::CTRL_SEL_HI] ? BREAK_MATCH_I[1] :
                 PERF_MON_I[1];
    end
  end
  assign BREAKPOINT_OUT_O = bp_q[3:2];
  assign SHARED_MONITOR_BREAK_OUT_O = bp_q[1:0];

  chk_abort_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    abort_act |=> st_q == cbc_pkg::CBC_HOLD && !ADDR_OE_O)
    else $error("abort did not float bus");
  chk_restart_cyc: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    st_q == cbc_pkg::CBC_HOLD && !abort_act && busy_q |=> ##1
    st_q == cbc_pkg::CBC_T1)
    else $error("aborted cycle not restarted");
  chk_rdy_states: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    done_q |-> $past(data_phase))
    else $error("ready taken outside data states");
  chk_req_level: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    REQ_VALID_I && REQ_READY_O |=> BUS_REQUEST_OUT_O)
    else $error("bus request not raised");
  chk_check_cap: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    chk_take |=> mca_q == $past(cyc_q.addr))
    else $error("check address not captured");
  chk_mce_gate: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    MACHINE_CHECK_O |-> $past(machine_check_enable_bit) || $past(pend_q))
    else $error("exception without enable");
  chk_stop_defer: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    pend_q && stop_act |=> !MACHINE_CHECK_O)
    else $error("exception taken under stop clock");
  chk_mon_reset: assert property (@(posedge CORE_CLK_I)
    !RST_N_I |=> SHARED_MONITOR_BREAK_OUT_O == 2'h0 &&
    ctrl_q[cbc_pkg::CTRL_SEL_LO] == 1'b0)
    else $error("shared pins not in monitor mode");
endmodule : cbc_bus_ctrl

// [testbench/cbc_chipset_model.sv]
// chipset model: answers bus cycles with burst-ready, read data and bus-check
`timescale 1ns/1ps
module cbc_chipset_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus from the block
  input wire logic addr_oe_i,
  input wire logic [cbc_pkg::AW-1:0] addr_i,
  // bench control
  input wire logic [3:0] delay_i,
  input wire logic use_copy_i,
  input wire logic bad_i,
  // answers
  output logic ready_n_o,
  output logic ready_copy_n_o,
  output logic bus_check_n_o,
  output logic [cbc_pkg::DW-1:0] data_o
);
  logic [3:0] wait_q;
  logic served_q;
  wire fire = addr_oe_i && !served_q && (wait_q == delay_i);
  // one answer per driven cycle; counter restarts when the bus floats
  always_ff @(posedge clk_i) begin
    ready_n_o <= !(fire && !use_copy_i);
    ready_copy_n_o <= !(fire && use_copy_i);
    bus_check_n_o <= !(fire && bad_i);
    // data valid only with the answer, toggling otherwise
    data_o <= fire ? {~addr_i, 6'h00, addr_i} : ~data_o;
    if (!rst_n_i || !addr_oe_i) begin
      wait_q <= 4'h0;
      served_q <= 1'b0;
    end else if (!served_q) begin
      wait_q <= wait_q + 4'h1;
      served_q <= fire;
    end
  end
endmodule : cbc_chipset_model

// [testbench/tb_top.sv]
// self-checking bench for the bus cycle control block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, abort_n = 1, req_v = 0, we = 0, re = 0;
  logic cp = 0, bad = 0, stp = 1, snp = 0, x0, x1, rdy_n, rdyc_n, bchk_n;
  logic bus_request_out, cstart, aoe, wr_o, req_rdy, done, mchk, irq;
  logic [1:0] strap = 2'h1, s, ratio, pm = 0, bp, smb;
  logic [3:0] bm = 0, ra = 0, dly = 0;
  logic [31:0] wd = 0, rd, v;
  logic [63:0] e;
  logic [cbc_pkg::DW-1:0] data;
  logic [cbc_pkg::AW-1:0] addr, a;
  cbc_pkg::cbc_cycle_s req_c = '0;
  int seed = 91438, fails = 0, num_checks = 0, cyc = 0, mc_n = 0, n;
  int cs_n = 0, c0;

  cbc_bus_ctrl #(.COLD_RESET_CYC(8)) i_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .BUS_RATIO_STRAP_I(strap),
    .ABORT_RETRY_N_I(abort_n), .BURST_READY_N_I(rdy_n),
    .BURST_READY_COPY_N_I(rdyc_n), .BUS_CHECK_N_I(bchk_n),
    .STOP_CLOCK_REQUEST_N_I(stp),
    .DATA_I(data), .BUS_REQUEST_OUT_O(bus_request_out), .CYCLE_START_O(cstart),
    .ADDR_O(addr), .ADDR_OE_O(aoe), .WRITE_O(wr_o), .BUS_RATIO_O(ratio),
    .REQ_VALID_I(req_v), .REQ_CYCLE_I(req_c), .REQ_READY_O(req_rdy),
    .DONE_O(done), .BREAK_MATCH_I(bm), .PERF_MON_I(pm),
    .BREAKPOINT_OUT_O(bp), .SHARED_MONITOR_BREAK_OUT_O(smb),
    .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(we), .REG_RD_I(re),
    .REG_RDATA_O(rd), .MACHINE_CHECK_O(mchk), .IRQ_O(irq));

  cbc_chipset_model i_chipset (
    .clk_i(clk), .rst_n_i(rst_n), .addr_oe_i(aoe), .addr_i(addr),
    .delay_i(dly), .use_copy_i(cp), .bad_i(bad), .ready_n_o(rdy_n),
    .ready_copy_n_o(rdyc_n), .bus_check_n_o(bchk_n), .data_o(data));

  initial forever #10 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mchk === 1'b1) mc_n <= mc_n + 1;
    if (cstart === 1'b1) cs_n <= cs_n + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [63:0] ex, g);
    num_checks++;
    if (g !== ex) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, g);
    end
  endtask : chk

  task automatic wreg(input logic [3:0] r, input logic [31:0] d);
    @(posedge clk);
    ra <= r;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] r, output logic [31:0] d);
    @(posedge clk);
    ra <= r;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rd;
  endtask : rreg

  task automatic rst(input int c);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (c) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask : rst

  // one core request, optional abort, waits for completion
  task automatic bus(input logic w, input logic [3:0] d, input logic c, ab);
    // snoop calls reuse the last address, so they hit the same line
    if (!snp) a = cbc_pkg::AW'($random(seed));
    c0 = cs_n;
    dly <= ab ? 4'h9 : d;
    cp <= c;
    @(posedge clk);
    req_c <= '{a, w, snp};
    req_v <= 1'b1;
    @(posedge clk);
    req_v <= 1'b0;
    #1 chk("bus_request_out", 1, bus_request_out);
    chk("req_rdy", 0, req_rdy);
    if (ab) begin
      repeat (2) @(posedge clk);
      abort_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk("aoe_hold", 0, aoe);
      @(posedge clk);
      abort_n <= 1'b1;
    end
    for (int k = 0; k < 60 && done !== 1'b1; k++) @(posedge clk) #1;
    chk("done", 1, done);
    chk("starts", ab ? 2 : 1, cs_n - c0);
    chk("addr", a, addr);
    chk("write", w, wr_o);
    e = {~a, 6'h00, a};
    if (!w) begin
      rreg(cbc_pkg::REG_DLO, v);
      chk("data_lo", e[31:0], v);
      rreg(cbc_pkg::REG_DHI, v);
      chk("data_hi", e[63:32], v);
    end
  endtask : bus

  initial begin
    strap = 2'($random(seed));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("ratio", strap, ratio);
    s = strap;
    strap = ~s;
    rst(3);
    chk("ratio_warm", s, ratio);
    rst(12);
    chk("ratio_cold", strap, ratio);
    rreg(cbc_pkg::REG_CTRL, v);
    chk("ctrl_rst", cbc_pkg::CTRL_RESET, v);
    rreg(4'hf, v);
    chk("unmapped", 0, v);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wreg(cbc_pkg::REG_CTRL, 32'(i));
      else @(posedge clk);
      bm <= 4'($random(seed));
      pm <= 2'($random(seed));
      repeat (3) @(posedge clk);
      #1 chk("bp", bm[3:2], bp);
      chk("smb", {i[1] ? bm[1] : pm[1], i[0] ? bm[0] : pm[0]}, smb);
    end
    for (int i = 0; i < 12; i++)
      bus(1'($random(seed)), 4'($unsigned($random(seed)) % 5), i[0], i == 5);
    rreg(cbc_pkg::REG_STAT, v);
    chk("st_abort", 1, v[cbc_pkg::EV_ABORT]);
    wreg(cbc_pkg::REG_CTRL, 32'h1 << cbc_pkg::CTRL_MCE);
    bad <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      n = mc_n;
      bus(1'b1, 4'h1, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk("mchk", 1 - m, mc_n - n);
      rreg(cbc_pkg::REG_MCA, v);
      chk("mca", a, v);
      rreg(cbc_pkg::REG_MCT, v);
      chk("mct", 1, v);
      wreg(cbc_pkg::REG_CTRL, 0);
    end
    // snoop checks under stop-clock: one deferred, then a same-line drop
    wreg(cbc_pkg::REG_CTRL, 32'h1 << cbc_pkg::CTRL_MCE);
    snp = 1'b1;
    for (int m = 0; m < 2; m++) begin
      n = mc_n;
      stp <= 1'b0;
      repeat (m + 1) bus(1'b0, 4'h1, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk("mchk_stop", 0, mc_n - n);
      stp <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("mchk_late", 1 - m, mc_n - n);
    end
    snp = 1'b0;
    rreg(cbc_pkg::REG_STAT, v);
    chk("st_drop", 1, v[cbc_pkg::EV_DROP]);
    bad <= 1'b0;
    wreg(cbc_pkg::REG_MASK, 0);
    @(posedge clk) #1 x0 = irq;
    wreg(cbc_pkg::REG_MASK, 32'hf);
    @(posedge clk) #1 x1 = irq;
    chk("irq_mask", 1, x0 ^ x1);
    wreg(cbc_pkg::REG_STAT, 32'hf);
    @(posedge clk) #1 chk("irq_clr", 0, irq);
    rreg(cbc_pkg::REG_STAT, v);
    chk("stat_clr", 0, v);
    print_verdict();
  end
endmodule : tb_top
